/* File: mrf_pkg.sv */
// Constants shared by the receive filter, queue and statistics block.
package mrf_pkg;
	localparam int NUM_ENTRIES = 16;
	localparam int NUM_MASKS = 2;
	localparam int WORD_BITS = 32;
	localparam int FWD_BIT_POS = 16;
	localparam int PORT_EN_BIT_POS = 30;
	localparam int LO_SIZE_RST_KB = 12;
	localparam int HI_SIZE_RST_KB = 8;
	localparam int SIZE_FIELD_BITS = 5;
	localparam int KB_BYTES = 1024;
	localparam int MIN_FREE_BYTES = 256;
	localparam int MIN_FRAME_BYTES = 64;
	localparam int MAX_FRAME_BYTES = 1518;
	localparam int DA_BYTES = 6;
	localparam int LEN_BITS = 11;
	localparam int OUT_FIFO_DEPTH = 16;
	localparam int NUM_COUNTERS = 15;
	localparam int CNT_RX_TOTAL = 0;
	localparam int CNT_RX_UCAST = 1;
	localparam int CNT_RX_MCAST = 2;
	localparam int CNT_RX_BCAST = 3;
	localparam int CNT_RX_CRC = 4;
	localparam int CNT_RX_ALIGN = 5;
	localparam int CNT_RX_PHY = 6;
	localparam int CNT_RX_LEN = 7;
	localparam int CNT_TX_TOTAL = 8;
	localparam int CNT_TX_UCAST = 9;
	localparam int CNT_TX_MCAST = 10;
	localparam int CNT_TX_BCAST = 11;
	localparam int CNT_RX_FULL = 12;
	localparam int CNT_RX_FILT = 13;
	localparam int CNT_RX_GAP = 14;
	localparam logic [31:0] CNT_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		MRF_IDLE = 2'b00,
		MRF_BODY = 2'b01,
		MRF_DROP = 2'b11
	} mrf_rx_state_t;
endpackage : mrf_pkg

/* File: mrf_rx_filter_queue.sv */
// Receive address filter, priority queues, host FIFO and statistics.
`timescale 1ns/10ps

module mrf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [CW-1:0] cap_in,
	input wire logic wr_valid_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic wr_ready_out,
	input wire logic wr_commit_in,
	input wire logic wr_discard_in,
	output logic [CW-1:0] free_out,
	output logic rd_valid_out,
	output logic [WIDTH-1:0] rd_data_out,
	input wire logic rd_ready_in
);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_idx_q, cmt_idx_q, rd_idx_q, wr_idx_inc;
	logic [CW-1:0] used_q, avail_q, used_d, avail_d;
	logic do_wr, do_rd;

	// Writes stay invisible to the reader until committed, so a frame can
	// be withdrawn whole when a late error or a filter miss is found.
	assign wr_ready_out = used_q < cap_in;
	assign free_out = wr_ready_out ? cap_in - used_q : '0;
	assign rd_valid_out = avail_q != '0;
	assign rd_data_out = mem_q[rd_idx_q];
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;
	assign wr_idx_inc = (wr_idx_q == LAST_IDX) ? '0 : wr_idx_q + 1'b1;

	always_comb begin
		used_d = used_q + CW'(do_wr) - CW'(do_rd);
		avail_d = avail_q - CW'(do_rd);
		if (wr_discard_in) begin
			used_d = avail_d;
		end else if (wr_commit_in) begin
			avail_d = used_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			used_q <= '0;
			avail_q <= '0;
		end else begin
			used_q <= used_d;
			avail_q <= avail_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_idx_q <= '0;
			cmt_idx_q <= '0;
			rd_idx_q <= '0;
		end else begin
			if (wr_discard_in) begin
				wr_idx_q <= cmt_idx_q;
			end else if (do_wr) begin
				wr_idx_q <= wr_idx_inc;
			end
			if (wr_commit_in && !wr_discard_in) begin
				cmt_idx_q <= do_wr ? wr_idx_inc : wr_idx_q;
			end
			if (do_rd) begin
				rd_idx_q <= (rd_idx_q == LAST_IDX) ? '0 : rd_idx_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (do_wr) begin
			mem_q[wr_idx_q] <= wr_data_in;
		end
	end
endmodule : mrf_fifo

module mrf_rx_filter_queue #(
	parameter int LO_DEPTH = mrf_pkg::LO_SIZE_RST_KB * mrf_pkg::KB_BYTES,
	parameter int HI_DEPTH = mrf_pkg::HI_SIZE_RST_KB * mrf_pkg::KB_BYTES,
	parameter int OUT_DEPTH = mrf_pkg::OUT_FIFO_DEPTH
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_last_in,
	input wire logic rx_er_in,
	input wire logic rx_crc_err_in,
	input wire logic rx_align_err_in,
	input wire logic rx_gap_err_in,
	input wire logic rx_high_prio_in,
	input wire logic [mrf_pkg::NUM_ENTRIES*32-1:0] filter_entry_upper_in,
	input wire logic [mrf_pkg::NUM_ENTRIES*32-1:0] filter_entry_lower_in,
	input wire logic [mrf_pkg::NUM_MASKS*32-1:0] filter_mask_upper_in,
	input wire logic [mrf_pkg::NUM_MASKS*32-1:0] filter_mask_lower_in,
	input wire logic forward_unmatched_en_in,
	input wire logic [mrf_pkg::SIZE_FIELD_BITS-1:0] low_prio_fifo_size_in,
	input wire logic [mrf_pkg::SIZE_FIELD_BITS-1:0] high_prio_fifo_size_in,
	input wire logic tx_done_in,
	input wire logic tx_multicast_in,
	input wire logic tx_broadcast_in,
	output logic host_valid_out,
	output logic [7:0] host_data_out,
	output logic host_last_out,
	input wire logic host_ready_in,
	output logic [31:0] rx_total_count_out,
	output logic [31:0] rx_unicast_count_out,
	output logic [31:0] rx_multicast_count_out,
	output logic [31:0] rx_broadcast_count_out,
	output logic [31:0] rx_crc_error_count_out,
	output logic [31:0] rx_alignment_error_count_out,
	output logic [31:0] rx_phy_error_count_out,
	output logic [31:0] rx_length_error_count_out,
	output logic [31:0] tx_total_count_out,
	output logic [31:0] tx_unicast_count_out,
	output logic [31:0] tx_multicast_count_out,
	output logic [31:0] tx_broadcast_count_out,
	output logic [31:0] rx_fifo_full_drop_count_out,
	output logic [31:0] rx_filter_drop_count_out,
	output logic [31:0] rx_gap_error_count_out
);
	localparam int NE = mrf_pkg::NUM_ENTRIES;
	localparam int LCW = $clog2(LO_DEPTH + 1);
	localparam int HCW = $clog2(HI_DEPTH + 1);
	localparam int OCW = $clog2(OUT_DEPTH + 1);
	localparam int LEN_W = mrf_pkg::LEN_BITS;
	localparam logic [LEN_W-1:0] LEN_MAX = '1;

	mrf_pkg::mrf_rx_state_t st_q;
	logic [LEN_W-1:0] len_q, len_cur;
	logic [47:0] da_q, da_cur;
	logic qhi_q, er_q, first, sel_hi, writing, room_ok;
	logic q_ready, q_wr, overflow, fin, bad, accept;
	logic commit, discard, lo_commit, hi_commit;
	logic [NE-1:0] hit, fwd;
	logic [LCW-1:0] lo_cap, lo_free;
	logic [HCW-1:0] hi_cap, hi_free;
	logic [31:0] lo_want, hi_want;
	logic lo_rdy, hi_rdy, lo_rv, hi_rv, out_rdy, use_hi, xfer;
	logic busy_q, sel_hi_q;
	logic [8:0] lo_rd, hi_rd, mv_word, out_word;
	logic [mrf_pkg::NUM_COUNTERS-1:0] inc;
	logic [31:0] cnt_q [mrf_pkg::NUM_COUNTERS];

	assign first = st_q == mrf_pkg::MRF_IDLE;
	assign len_cur = first ? LEN_W'(1) : ((len_q == LEN_MAX) ? len_q : len_q + 1'b1);
	assign da_cur = (len_cur <= LEN_W'(mrf_pkg::DA_BYTES)) ?
		{da_q[39:0], rx_data_in} : da_q;
	assign sel_hi = first ? rx_high_prio_in : qhi_q;
	assign room_ok = sel_hi ?
		(hi_free >= HCW'(mrf_pkg::MIN_FREE_BYTES)) :
		(lo_free >= LCW'(mrf_pkg::MIN_FREE_BYTES));
	assign writing = (first && room_ok) || st_q == mrf_pkg::MRF_BODY;
	assign q_ready = sel_hi ? hi_rdy : lo_rdy;
	assign q_wr = rx_valid_in && writing;
	assign overflow = q_wr && !q_ready;
	assign fin = rx_valid_in && rx_last_in;
	// A mask applies only to the first entries; the rest compare all bits.
	for (genvar i = 0; i < NE; i++) begin : g_entry
		logic [31:0] up, lw;
		logic [47:0] mask;
		assign up = filter_entry_upper_in[i*32 +: 32];
		assign lw = filter_entry_lower_in[i*32 +: 32];
		if (i < mrf_pkg::NUM_MASKS) begin : g_mask
			assign mask = {filter_mask_upper_in[i*32 +: 16],
				filter_mask_lower_in[i*32 +: 32]};
		end else begin : g_nomask
			assign mask = '1;
		end
		assign hit[i] = up[mrf_pkg::PORT_EN_BIT_POS] &&
			(((da_cur ^ {up[15:0], lw}) & mask) == '0);
		assign fwd[i] = hit[i] && up[mrf_pkg::FWD_BIT_POS];
	end

	// With every entry disabled and forward-unmatched clear, nothing passes.
	assign accept = (|fwd) || ((hit == '0) && forward_unmatched_en_in);
	assign bad = rx_crc_err_in || er_q || rx_er_in ||
		len_cur < LEN_W'(mrf_pkg::MIN_FRAME_BYTES) ||
		len_cur > LEN_W'(mrf_pkg::MAX_FRAME_BYTES);
	assign commit = q_wr && q_ready && rx_last_in && !bad && accept;
	assign discard = rx_valid_in && writing && (overflow || (rx_last_in && !commit));
	assign lo_commit = commit && !sel_hi;
	assign hi_commit = commit && sel_hi;
	assign lo_want = 32'(low_prio_fifo_size_in) * 32'(mrf_pkg::KB_BYTES);
	assign hi_want = 32'(high_prio_fifo_size_in) * 32'(mrf_pkg::KB_BYTES);
	assign lo_cap = (lo_want > 32'(LO_DEPTH)) ? LCW'(LO_DEPTH) :
		LCW'(lo_want);
	assign hi_cap = (hi_want > 32'(HI_DEPTH)) ? HCW'(HI_DEPTH) :
		HCW'(hi_want);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= mrf_pkg::MRF_IDLE;
		end else if (rx_valid_in) begin
			if (rx_last_in) begin
				st_q <= mrf_pkg::MRF_IDLE;
			end else if (overflow || !writing) begin
				st_q <= mrf_pkg::MRF_DROP;
			end else begin
				st_q <= mrf_pkg::MRF_BODY;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			len_q <= '0;
			da_q <= '0;
			qhi_q <= 1'b0;
			er_q <= 1'b0;
		end else begin
			if (rx_valid_in) begin
				len_q <= len_cur;
				da_q <= da_cur;
				qhi_q <= sel_hi;
			end
			if (fin) begin
				er_q <= 1'b0;
			end else if (rx_er_in && !first) begin
				er_q <= 1'b1;
			end
		end
	end

	mrf_fifo #(.WIDTH(9), .DEPTH(LO_DEPTH)) u_lo_q (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.cap_in(lo_cap),
		.wr_valid_in(q_wr && !sel_hi),
		.wr_data_in({rx_last_in, rx_data_in}),
		.wr_ready_out(lo_rdy),
		.wr_commit_in(lo_commit),
		.wr_discard_in(discard && !sel_hi),
		.free_out(lo_free),
		.rd_valid_out(lo_rv),
		.rd_data_out(lo_rd),
		.rd_ready_in(xfer && !use_hi)
	);

	mrf_fifo #(.WIDTH(9), .DEPTH(HI_DEPTH)) u_hi_q (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.cap_in(hi_cap),
		.wr_valid_in(q_wr && sel_hi),
		.wr_data_in({rx_last_in, rx_data_in}),
		.wr_ready_out(hi_rdy),
		.wr_commit_in(hi_commit),
		.wr_discard_in(discard && sel_hi),
		.free_out(hi_free),
		.rd_valid_out(hi_rv),
		.rd_data_out(hi_rd),
		.rd_ready_in(xfer && use_hi)
	);

	// A frame in flight is never interrupted; the choice is made between
	// frames, where a waiting high priority frame always wins.
	assign use_hi = busy_q ? sel_hi_q : hi_rv;
	assign mv_word = use_hi ? hi_rd : lo_rd;
	assign xfer = (use_hi ? hi_rv : lo_rv) && out_rdy;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_q <= 1'b0;
			sel_hi_q <= 1'b0;
		end else if (xfer) begin
			busy_q <= !mv_word[8];
			sel_hi_q <= use_hi;
		end
	end

	mrf_fifo #(.WIDTH(9), .DEPTH(OUT_DEPTH)) u_out_q (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.cap_in(OCW'(OUT_DEPTH)),
		.wr_valid_in(xfer),
		.wr_data_in(mv_word),
		.wr_ready_out(out_rdy),
		.wr_commit_in(1'b1),
		.wr_discard_in(1'b0),
		.free_out(),
		.rd_valid_out(host_valid_out),
		.rd_data_out(out_word),
		.rd_ready_in(host_ready_in)
	);

	assign host_data_out = out_word[7:0];
	assign host_last_out = out_word[8];
	// Error events bump counters, and CRC and PHY errors also drop the frame; this block has no interrupt path.
	always_comb begin
		inc = '0;
		inc[mrf_pkg::CNT_RX_TOTAL] = fin;
		inc[mrf_pkg::CNT_RX_BCAST] = fin && (da_cur == '1);
		inc[mrf_pkg::CNT_RX_MCAST] = fin && da_cur[40] && (da_cur != '1);
		inc[mrf_pkg::CNT_RX_UCAST] = fin && !da_cur[40];
		inc[mrf_pkg::CNT_RX_CRC] = fin && rx_crc_err_in;
		inc[mrf_pkg::CNT_RX_ALIGN] = fin && rx_align_err_in;
		inc[mrf_pkg::CNT_RX_PHY] = fin && (er_q || rx_er_in);
		inc[mrf_pkg::CNT_RX_LEN] = fin &&
			(len_cur < LEN_W'(mrf_pkg::MIN_FRAME_BYTES) ||
			len_cur > LEN_W'(mrf_pkg::MAX_FRAME_BYTES));
		inc[mrf_pkg::CNT_TX_TOTAL] = tx_done_in;
		inc[mrf_pkg::CNT_TX_BCAST] = tx_done_in && tx_broadcast_in;
		inc[mrf_pkg::CNT_TX_MCAST] = tx_done_in && tx_multicast_in &&
			!tx_broadcast_in;
		inc[mrf_pkg::CNT_TX_UCAST] = tx_done_in && !tx_multicast_in &&
			!tx_broadcast_in;
		inc[mrf_pkg::CNT_RX_FULL] = rx_valid_in &&
			((first && !room_ok) || overflow);
		inc[mrf_pkg::CNT_RX_FILT] = fin && writing && !overflow && !bad &&
			!accept;
		inc[mrf_pkg::CNT_RX_GAP] = fin && rx_gap_err_in;
	end

	for (genvar c = 0; c < mrf_pkg::NUM_COUNTERS; c++) begin : g_cnt
		always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				cnt_q[c] <= mrf_pkg::CNT_RST;
			end else if (inc[c]) begin
				cnt_q[c] <= cnt_q[c] + 32'h0000_0001;
			end
		end
	end
	assign rx_total_count_out = cnt_q[mrf_pkg::CNT_RX_TOTAL];
	assign rx_unicast_count_out = cnt_q[mrf_pkg::CNT_RX_UCAST];
	assign rx_multicast_count_out = cnt_q[mrf_pkg::CNT_RX_MCAST];
	assign rx_broadcast_count_out = cnt_q[mrf_pkg::CNT_RX_BCAST];
	assign rx_crc_error_count_out = cnt_q[mrf_pkg::CNT_RX_CRC];
	assign rx_alignment_error_count_out = cnt_q[mrf_pkg::CNT_RX_ALIGN];
	assign rx_phy_error_count_out = cnt_q[mrf_pkg::CNT_RX_PHY];
	assign rx_length_error_count_out = cnt_q[mrf_pkg::CNT_RX_LEN];
	assign tx_total_count_out = cnt_q[mrf_pkg::CNT_TX_TOTAL];
	assign tx_unicast_count_out = cnt_q[mrf_pkg::CNT_TX_UCAST];
	assign tx_multicast_count_out = cnt_q[mrf_pkg::CNT_TX_MCAST];
	assign tx_broadcast_count_out = cnt_q[mrf_pkg::CNT_TX_BCAST];
	assign rx_fifo_full_drop_count_out = cnt_q[mrf_pkg::CNT_RX_FULL];
	assign rx_filter_drop_count_out = cnt_q[mrf_pkg::CNT_RX_FILT];
	assign rx_gap_error_count_out = cnt_q[mrf_pkg::CNT_RX_GAP];
endmodule : mrf_rx_filter_queue

/* File: mrf_checker_assertions.sv */
// Port-level assertions for the receive filter and queue block.
`timescale 1ns/10ps
module mrf_checker (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic rx_valid_in,
	input wire logic rx_last_in,
	input wire logic rx_crc_err_in,
	input wire logic rx_gap_err_in,
	input wire logic tx_done_in,
	input wire logic host_valid_out,
	input wire logic [7:0] host_data_out,
	input wire logic host_last_out,
	input wire logic host_ready_in,
	input wire logic [31:0] rx_total_count_out,
	input wire logic [31:0] rx_unicast_count_out,
	input wire logic [31:0] rx_multicast_count_out,
	input wire logic [31:0] rx_broadcast_count_out,
	input wire logic [31:0] rx_crc_error_count_out,
	input wire logic [31:0] rx_gap_error_count_out,
	input wire logic [31:0] rx_filter_drop_count_out,
	input wire logic [31:0] tx_total_count_out
);
	logic rx_end;
	logic [31:0] cls_sum;
	assign rx_end = rx_valid_in && rx_last_in;
	// Exactly one class counter moves per frame end, so the sum steps by one.
	assign cls_sum = rx_unicast_count_out + rx_multicast_count_out +
		rx_broadcast_count_out;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_reset_idle: assert property ($rose(rst_n_in) |->
		!host_valid_out && rx_total_count_out == 32'h0) else $error("busy");
	a_host_hold: assert property (host_valid_out && !host_ready_in |=>
		host_valid_out && $stable(host_data_out) && $stable(host_last_out))
		else $error("host byte moved while stalled");
	a_total_inc: assert property (rx_end |=>
		rx_total_count_out == $past(rx_total_count_out) + 32'h1)
		else $error("frame count did not step");
	a_class_once: assert property (rx_end |=>
		cls_sum == $past(cls_sum) + 32'h1) else $error("class counts wrong");
	a_crc_count: assert property (rx_end && rx_crc_err_in |=>
		rx_crc_error_count_out == $past(rx_crc_error_count_out) + 32'h1)
		else $error("crc count did not step");
	a_gap_count: assert property (rx_end && rx_gap_err_in |=>
		rx_gap_error_count_out == $past(rx_gap_error_count_out) + 32'h1)
		else $error("gap count did not step");
	a_err_not_filt: assert property (rx_end && rx_crc_err_in |=>
		$stable(rx_filter_drop_count_out)) else $error("bad frame filtered");
	a_tx_count: assert property (tx_done_in |=>
		tx_total_count_out == $past(tx_total_count_out) + 32'h1)
		else $error("tx count did not step");
	cover property (host_valid_out && host_ready_in && host_last_out);
	cover property (rx_end && rx_crc_err_in);
	cover property (host_valid_out && !host_ready_in);
endmodule : mrf_checker

bind mrf_rx_filter_queue mrf_checker i_chk (.sys_clk_in, .rst_n_in,
	.rx_valid_in, .rx_last_in, .rx_crc_err_in, .rx_gap_err_in, .tx_done_in,
	.host_valid_out, .host_data_out, .host_last_out, .host_ready_in,
	.rx_total_count_out, .rx_unicast_count_out, .rx_multicast_count_out,
	.rx_broadcast_count_out, .rx_crc_error_count_out,
	.rx_gap_error_count_out, .rx_filter_drop_count_out, .tx_total_count_out);

/* File: mrf_far_model.sv */
// Model of the receive byte source and the host-side reader.
`timescale 1ns/10ps
module mrf_far_model (
	input wire logic sys_clk_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_last_out,
	output logic rx_er_out,
	output logic rx_crc_err_out,
	output logic rx_align_err_out,
	output logic rx_gap_err_out,
	output logic rx_high_prio_out,
	output logic host_ready_out
);
	logic stall = 1'b0;
	initial begin
		rx_high_prio_out = 1'b0;
		rx_data_out = 8'h00;
		quiet();
	end
	// Ready is withheld at random so the output queue backs up mid-frame.
	always @(negedge sys_clk_in) begin
		host_ready_out <= !stall && ($urandom % 4 != 0);
	end
	task automatic quiet();
		rx_valid_out = 1'b0;
		rx_last_out = 1'b0;
		{rx_er_out, rx_crc_err_out, rx_align_err_out, rx_gap_err_out} = 4'h0;
		rx_data_out = ~rx_data_out;
	endtask : quiet
	task automatic send(input logic [7:0] b[$], input logic hi,
		input logic [3:0] e, input bit b2b);
		foreach (b[i]) begin
			@(negedge sys_clk_in);
			rx_valid_out = 1'b1;
			rx_data_out = b[i];
			rx_last_out = (i == b.size() - 1);
			rx_high_prio_out = hi;
			rx_er_out = e[3] && i == 1;
			{rx_crc_err_out, rx_align_err_out, rx_gap_err_out} =
				rx_last_out ? e[2:0] : 3'h0;
		end
		if (!b2b) begin
			@(negedge sys_clk_in);
			quiet();
		end
	endtask : send
endmodule : mrf_far_model

/* File: tb.sv */
// Self-checking bench for the receive filter, queues and statistics.
`timescale 1ns/10ps
module tb;
	localparam logic [47:0] DA_A = 48'h02AB_CD00_1122;
	localparam logic [47:0] DA_B = 48'h0211_2233_4455;
	localparam logic [47:0] DA_C = 48'h0266_7788_99AA;
	localparam logic [47:0] DA_M = 48'h0800_005A_6400;
	int lens[4] = '{63, 64, 1518, 1519};
	int flen[6] = '{500, 500, 500, 700, 500, 100};
	bit fdrop[6] = '{0, 0, 0, 1, 0, 1};
	int failures = 0;
	int total_checks = 0;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [511:0] filter_entry_upper_in = '0;
	logic [511:0] filter_entry_lower_in = '0;
	logic [63:0] filter_mask_upper_in = 64'h0000_FFFF_0000_FFFF;
	logic [63:0] filter_mask_lower_in = 64'hFFFF_FFFF_FFFF_FFFF;
	logic forward_unmatched_en_in = 1'b0;
	logic tx_done_in = 1'b0;
	logic tx_multicast_in = 1'b0;
	logic tx_broadcast_in = 1'b0;
	// Sizes never move during the run, since traffic flows from the start.
	logic [4:0] low_prio_fifo_size_in = 5'h02;
	logic [4:0] high_prio_fifo_size_in = 5'h02;
	wire rx_valid_in, rx_last_in, rx_er_in, rx_crc_err_in, rx_align_err_in;
	wire rx_gap_err_in, rx_high_prio_in, host_ready_in, host_valid_out;
	wire host_last_out;
	wire [7:0] rx_data_in, host_data_out;
	wire [31:0] cnt [15];
	logic [31:0] exp_cnt [15];
	logic [8:0] exp_q[$], hold_q[$];

	always #5 sys_clk_in = ~sys_clk_in;

	mrf_far_model i_far (.sys_clk_in, .rx_valid_out(rx_valid_in),
		.rx_data_out(rx_data_in), .rx_last_out(rx_last_in),
		.rx_er_out(rx_er_in), .rx_crc_err_out(rx_crc_err_in),
		.rx_align_err_out(rx_align_err_in), .rx_gap_err_out(rx_gap_err_in),
		.rx_high_prio_out(rx_high_prio_in), .host_ready_out(host_ready_in));

	mrf_rx_filter_queue #(.LO_DEPTH(2048), .HI_DEPTH(2048)) i_dut (
		.sys_clk_in, .rst_n_in, .rx_valid_in, .rx_data_in, .rx_last_in,
		.rx_er_in, .rx_crc_err_in, .rx_align_err_in, .rx_gap_err_in,
		.rx_high_prio_in, .filter_entry_upper_in, .filter_entry_lower_in,
		.filter_mask_upper_in, .filter_mask_lower_in, .forward_unmatched_en_in,
		.low_prio_fifo_size_in, .high_prio_fifo_size_in, .tx_done_in,
		.tx_multicast_in, .tx_broadcast_in, .host_valid_out, .host_data_out,
		.host_last_out, .host_ready_in,
		.rx_total_count_out(cnt[0]), .rx_unicast_count_out(cnt[1]),
		.rx_multicast_count_out(cnt[2]), .rx_broadcast_count_out(cnt[3]),
		.rx_crc_error_count_out(cnt[4]), .rx_alignment_error_count_out(cnt[5]),
		.rx_phy_error_count_out(cnt[6]), .rx_length_error_count_out(cnt[7]),
		.tx_total_count_out(cnt[8]), .tx_unicast_count_out(cnt[9]),
		.tx_multicast_count_out(cnt[10]), .tx_broadcast_count_out(cnt[11]),
		.rx_fifo_full_drop_count_out(cnt[12]),
		.rx_filter_drop_count_out(cnt[13]), .rx_gap_error_count_out(cnt[14]));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task final_report();
		if (failures == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report

	function automatic bit accept(input logic [47:0] da);
		logic [31:0] u;
		logic [47:0] m;
		bit hit;
		hit = 0;
		accept = 0;
		for (int i = 0; i < 16; i++) begin
			u = filter_entry_upper_in[i*32 +: 32];
			m = i < 2 ? {filter_mask_upper_in[i*32 +: 16],
				filter_mask_lower_in[i*32 +: 32]} : '1;
			if (u[30] && ((({u[15:0], filter_entry_lower_in[i*32 +: 32]} ^ da)
				& m) == 48'h0)) begin
				hit = 1;
				accept |= u[16];
			end
		end
		if (!hit) accept = forward_unmatched_en_in;
	endfunction : accept

	task set_ent(input int i, input logic [47:0] da, input logic fwd,
		input logic en);
		filter_entry_upper_in[i*32 +: 32] = {1'b0, en, 13'h0, fwd, da[47:32]};
		filter_entry_lower_in[i*32 +: 32] = da[31:0];
	endtask : set_ent

	task automatic frame(input logic [47:0] da, input int len, input logic hi,
		input logic [3:0] e, input bit b2b, input bit full, input bit defer);
		logic [7:0] b[$];
		logic [8:0] w;
		bit bad;
		bad = e[3] || e[2] || len < 64 || len > 1518;
		for (int i = 0; i < len; i++)
			b.push_back(i < 6 ? da[47 - 8 * i -: 8] : 8'($urandom));
		exp_cnt[0]++;
		if (&da) exp_cnt[3]++;
		else if (da[40]) exp_cnt[2]++;
		else exp_cnt[1]++;
		exp_cnt[6] += 32'(e[3]);
		exp_cnt[4] += 32'(e[2]);
		exp_cnt[5] += 32'(e[1]);
		exp_cnt[14] += 32'(e[0]);
		exp_cnt[7] += 32'(len < 64 || len > 1518);
		if (full) exp_cnt[12]++;
		else if (!bad && !accept(da)) exp_cnt[13]++;
		else if (!bad) foreach (b[i]) begin
			w = {1'(i == len - 1), b[i]};
			if (defer) hold_q.push_back(w);
			else exp_q.push_back(w);
		end
		i_far.send(b, hi, e, b2b);
	endtask : frame

	task drain();
		for (int n = 0; n < 5000 && exp_q.size() != 0; n++)
			@(negedge sys_clk_in);
		repeat (40) @(negedge sys_clk_in);
		foreach (exp_cnt[i]) check(cnt[i], exp_cnt[i]);
		check(32'(exp_q.size()), 32'h0000_0000);
	endtask : drain

	always @(posedge sys_clk_in) begin
		if (host_valid_out === 1'b1 && host_ready_in === 1'b1)
			check({host_last_out, host_data_out},
				exp_q.size() ? exp_q.pop_front() : 9'h1XX);
	end

	initial begin
		repeat (60000) @(posedge sys_clk_in);
		failures++;
		final_report();
	end

	initial begin
		logic [47:0] da;
		bit hi;
		foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
		void'($urandom(32'h0919));
		repeat (12) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		rst_n_in = 1'b1;
		frame(DA_A, 80, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
		set_ent(3, DA_A, 1'b1, 1'b1);
		set_ent(4, DA_B, 1'b1, 1'b0);
		set_ent(5, DA_C, 1'b0, 1'b1);
		set_ent(0, DA_M, 1'b1, 1'b1);
		filter_mask_lower_in[31:0] = 32'hFFFF_FF00;
		for (int k = 0; k < 20; k++) begin
			// One priority per half keeps the expected delivery order exact.
			if (k % 10 == 0) begin
				drain();
				hi = 1'($urandom);
			end
			forward_unmatched_en_in = (k >= 10);
			case ($urandom % 5)
				0: da = DA_A;
				1: da = DA_B;
				2: da = DA_C;
				3: da = 48'hFFFF_FFFF_FFFF;
				default: da = DA_M ^ 48'($urandom % 512);
			endcase
			if (k % 3 == 0) da = 48'({$urandom, $urandom});
			frame(da, 64 + $urandom % 137, hi, 4'h0,
				1'(k % 10 != 9 && $urandom % 2), 1'b0, 1'b0);
		end
		drain();
		foreach (lens[k]) frame(DA_A, lens[k], 1'(k), 4'h0, 0, 0, 0);
		for (int k = 0; k < 4; k++)
			frame(DA_A, 70, 1'b0, 4'(1 << k), 1'(k < 3), 0, 0);
		for (int k = 0; k < 8; k++) begin
			@(negedge sys_clk_in);
			da[1:0] = 2'($urandom % 3);
			{tx_done_in, tx_broadcast_in, tx_multicast_in} = {1'b1, da[1:0]};
			exp_cnt[8]++;
			exp_cnt[9 + da[1:0]]++;
		end
		@(negedge sys_clk_in);
		tx_done_in = 1'b0;
		drain();
		i_far.stall = 1'b1;
		frame(DA_A, 100, 1'b0, 4'h0, 0, 0, 0);
		frame(DA_A, 80, 1'b0, 4'h0, 0, 0, 1);
		frame(DA_A, 90, 1'b1, 4'h0, 0, 0, 0);
		while (hold_q.size() != 0) exp_q.push_back(hold_q.pop_front());
		i_far.stall = 1'b0;
		drain();
		i_far.stall = 1'b1;
		foreach (flen[k]) frame(DA_A, flen[k], 1'b1, 4'h0, 0, fdrop[k], 0);
		i_far.stall = 1'b0;
		drain();
		final_report();
	end
endmodule : tb
